// File: rtl/ddrs_pkg.sv
/*
 * Shared constants and types for the drive data register store.
 * Assumes a single 10 MHz clock and character-coded register names.
 */
package ddrs_pkg;

    // Clock and counter timer resolution
    localparam int CLK_PERIOD_NS = 100;
    localparam int TIMER_RES_NS = 100000;
    localparam int TIMER_RES_ALT_NS = 125000;
    localparam int TIMER_CYCLES = TIMER_RES_NS / CLK_PERIOD_NS;
    localparam int TIMER_ALT_CYCLES = TIMER_RES_ALT_NS / CLK_PERIOD_NS;

    // Register population
    localparam int NUM_REGS = 75;
    localparam logic [6:0] RO_BASE = 7'h00;
    localparam logic [6:0] RW_BASE = 7'h1a;
    localparam logic [6:0] DIG_BASE = 7'h34;
    localparam logic [6:0] SYM_BASE = 7'h3e;

    // Character ranges of the register classes
    localparam logic [7:0] CH_LO_FIRST = 8'h61;
    localparam logic [7:0] CH_LO_LAST = 8'h7a;
    localparam logic [7:0] CH_UP_FIRST = 8'h41;
    localparam logic [7:0] CH_UP_LAST = 8'h5a;
    localparam logic [7:0] CH_DIG_FIRST = 8'h30;
    localparam logic [7:0] CH_DIG_LAST = 8'h39;
    localparam logic [7:0] CH_SYM_FIRST = 8'h21;
    localparam logic [7:0] CH_SYM_LAST = 8'h2d;
    localparam logic [7:0] CH_SPEED = 8'h56;
    localparam logic [7:0] CH_COUNTER = 8'h49;

    // Storage slots
    localparam int NV_SLOTS = 100;
    localparam logic [6:0] SLOT_FIRST = 7'h01;
    localparam logic [6:0] SLOT_LAST = 7'h64;

    // Upload limits
    localparam logic [3:0] UPLOAD_MAX = 4'ha;
    localparam logic [3:0] UPLOAD_ONE = 4'h1;

    // Counter-assign field layout inside reg_b
    localparam int CA_IN_LSB = 0;
    localparam int CA_MODE_LSB = 4;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        NO_CMD = 4'h0,
        LOAD_NOW_CMD = 4'h1,
        UPLOAD_ONE_CMD = 4'h2,
        MULTI_UPLOAD_CMD = 4'h3,
        LOAD_QUEUED_CMD = 4'h4,
        SPEED_SET_CMD = 4'h5,
        NV_SAVE_CMD = 4'h6,
        NV_RESTORE_CMD = 4'h7,
        COPY_CMD = 4'h8,
        INC_CMD = 4'h9,
        DEC_CMD = 4'ha,
        INPUT_COUNT_ASSIGN_CMD = 4'hb
    } ddrs_op_t;

    typedef enum logic [1:0] {
        CNT_HIGH = 2'h0,
        CNT_LOW = 2'h1,
        CNT_RISE = 2'h2,
        CNT_FALL = 2'h3
    } ddrs_cnt_mode_t;

    typedef struct packed {
        ddrs_op_t op;
        logic [7:0] reg_a;
        logic [7:0] reg_b;
        logic [6:0] slot;
        logic [3:0] count;
        logic [31:0] data;
    } ddrs_cmd_t;

    typedef struct packed {
        logic [7:0] chr;
        logic [31:0] data;
        logic last;
    } ddrs_up_word_t;

endpackage

// File: rtl/ddrs_input_counter.sv
/*
 * Input counter engine: picks one digital input and emits a count pulse
 * per timer tick while a level holds, or per selected edge.
 * Assumes raw inputs are asynchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ddrs_input_counter #(
    parameter bit ALT_RES = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_din,
    input wire logic i_assign,
    input wire logic [2:0] i_sel,
    input wire ddrs_pkg::ddrs_cnt_mode_t i_mode,
    output logic o_pulse
);

    localparam int TICKS = ALT_RES ? ddrs_pkg::TIMER_ALT_CYCLES
                                   : ddrs_pkg::TIMER_CYCLES;
    localparam logic [10:0] TICK_LAST = 11'(TICKS - 1);

    logic [7:0] din_meta;
    logic [7:0] din_sync;
    logic [7:0] din_prev;
    logic enabled;
    logic [2:0] sel;
    ddrs_pkg::ddrs_cnt_mode_t mode;
    logic [10:0] tick_cnt;
    logic tick;
    logic lvl;
    logic lvl_prev;

    // Two-stage synchroniser, then a history stage for edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            din_meta <= 8'h00;
            din_sync <= 8'h00;
            din_prev <= 8'h00;
        end else begin
            din_meta <= i_din;
            din_sync <= din_meta;
            din_prev <= din_sync;
        end
    end

    // Input binding
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enabled <= 1'b0;
            sel <= 3'h0;
            mode <= ddrs_pkg::CNT_HIGH;
        end else if (i_assign) begin
            enabled <= 1'b1;
            sel <= i_sel;
            mode <= i_mode;
        end
    end

    // Timer resolution divider
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt <= 11'h000;
        end else if (tick) begin
            tick_cnt <= 11'h000;
        end else begin
            tick_cnt <= tick_cnt + 11'h001;
        end
    end

    assign tick = (tick_cnt == TICK_LAST);
    assign lvl = din_sync[sel];
    assign lvl_prev = din_prev[sel];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pulse <= 1'b0;
        end else if (!enabled || i_assign) begin
            o_pulse <= 1'b0;
        end else begin
            unique case (mode)
                ddrs_pkg::CNT_HIGH: o_pulse <= tick && lvl;
                ddrs_pkg::CNT_LOW: o_pulse <= tick && !lvl;
                ddrs_pkg::CNT_RISE: o_pulse <= lvl && !lvl_prev;
                ddrs_pkg::CNT_FALL: o_pulse <= !lvl && lvl_prev;
            endcase
        end
    end

endmodule

`default_nettype wire

// File: rtl/ddrs_nv_slots.sv
/*
 * Storage slot array: one data register value per slot, no reset.
 * Assumes the caller has checked the slot index; read data is one
 * cycle after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module ddrs_nv_slots (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [6:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata
);

    logic [31:0] slots [0:ddrs_pkg::NV_SLOTS-1];

    // Contents survive reset; only power loss erases them
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            slots[i_addr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_re) begin
            o_rdata <= slots[i_addr];
        end
    end

endmodule

`default_nettype wire

// File: rtl/ddrs_store.sv
/*
 * Drive data register store: 75 character-addressed registers with an
 * immediate command port, an in-order program command port, uploads,
 * storage slots, copy, increment/decrement and an input counter.
 * Assumes command ports are driven from logic on I_MCLK and I_DIN pins
 * are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module ddrs_store #(
    parameter bit PROG_CAPABLE = 1'b1,
    parameter bit ALT_RES = 1'b0
) (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_IMM_VALID,
    input wire ddrs_pkg::ddrs_cmd_t I_IMM_CMD,
    input wire logic I_PRG_VALID,
    input wire ddrs_pkg::ddrs_cmd_t I_PRG_CMD,
    output logic O_PRG_READY,
    input wire logic I_RO_WE,
    input wire logic [7:0] I_RO_CHAR,
    input wire logic [31:0] I_RO_DATA,
    input wire logic [7:0] I_DIN,
    output logic O_UP_VALID,
    output ddrs_pkg::ddrs_up_word_t O_UP_WORD,
    output logic [31:0] O_SPEED
);

    typedef enum logic [1:0] {
        PS_IDLE = 2'b01,
        PS_RESTORE = 2'b10
    } ddrs_prg_state_t;

    typedef enum logic [1:0] {
        US_IDLE = 2'b01,
        US_SEND = 2'b10
    } ddrs_up_state_t;

    // Character to {valid, index}; user class only in program variant
    function automatic logic [7:0] char_idx(input logic [7:0] c);
        logic [7:0] r;
        r = 8'h00;
        if (c >= ddrs_pkg::CH_LO_FIRST && c <= ddrs_pkg::CH_LO_LAST) begin
            r = {1'b1, 7'(c - ddrs_pkg::CH_LO_FIRST) + ddrs_pkg::RO_BASE};
        end else if (c >= ddrs_pkg::CH_UP_FIRST &&
                     c <= ddrs_pkg::CH_UP_LAST) begin
            r = {1'b1, 7'(c - ddrs_pkg::CH_UP_FIRST) + ddrs_pkg::RW_BASE};
        end else if (PROG_CAPABLE && c >= ddrs_pkg::CH_DIG_FIRST &&
                     c <= ddrs_pkg::CH_DIG_LAST) begin
            r = {1'b1, 7'(c - ddrs_pkg::CH_DIG_FIRST) + ddrs_pkg::DIG_BASE};
        end else if (PROG_CAPABLE && c >= ddrs_pkg::CH_SYM_FIRST &&
                     c <= ddrs_pkg::CH_SYM_LAST) begin
            r = {1'b1, 7'(c - ddrs_pkg::CH_SYM_FIRST) + ddrs_pkg::SYM_BASE};
        end
        return r;
    endfunction

    // Valid and not read-only
    function automatic logic writable(input logic [7:0] c);
        logic [7:0] r;
        r = char_idx(c);
        return r[7] && (r[6:0] >= ddrs_pkg::RW_BASE);
    endfunction

    function automatic logic slot_ok(input logic [6:0] s);
        return PROG_CAPABLE && s >= ddrs_pkg::SLOT_FIRST &&
               s <= ddrs_pkg::SLOT_LAST;
    endfunction

    logic [31:0] regs [0:ddrs_pkg::NUM_REGS-1];

    ddrs_prg_state_t prg_state;
    ddrs_up_state_t up_state;
    logic prg_take;
    logic [7:0] a_idx;
    logic [7:0] b_idx;
    logic [7:0] imm_idx;
    logic [7:0] ro_idx;
    logic [7:0] up_idx;
    logic [7:0] speed_idx;
    logic [7:0] cnt_idx;
    logic prg_wr;
    logic [6:0] prg_wr_idx;
    logic [31:0] prg_wr_data;
    logic nv_we;
    logic nv_re;
    logic [6:0] nv_addr;
    logic [31:0] nv_rdata;
    logic [6:0] restore_idx;
    logic cnt_assign;
    logic cnt_pulse;
    logic imm_load;
    logic imm_upload;
    logic [7:0] up_ptr;
    logic [3:0] up_left;
    logic [3:0] next_up_count;

    assign prg_take = I_PRG_VALID && O_PRG_READY;
    assign a_idx = char_idx(I_PRG_CMD.reg_a);
    assign b_idx = char_idx(I_PRG_CMD.reg_b);
    assign imm_idx = char_idx(I_IMM_CMD.reg_a);
    assign ro_idx = char_idx(I_RO_CHAR);
    assign up_idx = char_idx(up_ptr);
    assign speed_idx = char_idx(ddrs_pkg::CH_SPEED);
    assign cnt_idx = char_idx(ddrs_pkg::CH_COUNTER);

    // Only loads and speed sets write from the immediate port
    assign imm_load = I_IMM_VALID &&
        ((I_IMM_CMD.op == ddrs_pkg::LOAD_NOW_CMD &&
          writable(I_IMM_CMD.reg_a)) ||
         I_IMM_CMD.op == ddrs_pkg::SPEED_SET_CMD);
    assign imm_upload = I_IMM_VALID && up_state == US_IDLE &&
        (I_IMM_CMD.op == ddrs_pkg::UPLOAD_ONE_CMD ||
         I_IMM_CMD.op == ddrs_pkg::MULTI_UPLOAD_CMD);

    // Program port decode
    always_comb begin
        prg_wr = 1'b0;
        prg_wr_idx = a_idx[6:0];
        prg_wr_data = I_PRG_CMD.data;
        nv_we = 1'b0;
        nv_re = 1'b0;
        nv_addr = 7'(I_PRG_CMD.slot - ddrs_pkg::SLOT_FIRST);
        cnt_assign = 1'b0;
        if (prg_take) begin
            unique case (I_PRG_CMD.op)
                ddrs_pkg::LOAD_QUEUED_CMD: begin
                    prg_wr = writable(I_PRG_CMD.reg_a);
                end
                ddrs_pkg::SPEED_SET_CMD: begin
                    prg_wr = 1'b1;
                    prg_wr_idx = speed_idx[6:0];
                end
                ddrs_pkg::NV_SAVE_CMD: begin
                    nv_we = a_idx[7] && slot_ok(I_PRG_CMD.slot);
                    prg_wr_data = regs[a_idx[6:0]];
                end
                ddrs_pkg::NV_RESTORE_CMD: begin
                    nv_re = writable(I_PRG_CMD.reg_a) &&
                            slot_ok(I_PRG_CMD.slot);
                end
                ddrs_pkg::COPY_CMD: begin
                    prg_wr = a_idx[7] && writable(I_PRG_CMD.reg_b);
                    prg_wr_idx = b_idx[6:0];
                    prg_wr_data = regs[a_idx[6:0]];
                end
                ddrs_pkg::INC_CMD: begin
                    prg_wr = writable(I_PRG_CMD.reg_a);
                    prg_wr_data = regs[a_idx[6:0]] + 32'h0000_0001;
                end
                ddrs_pkg::DEC_CMD: begin
                    prg_wr = writable(I_PRG_CMD.reg_a);
                    prg_wr_data = regs[a_idx[6:0]] - 32'h0000_0001;
                end
                ddrs_pkg::INPUT_COUNT_ASSIGN_CMD: begin
                    cnt_assign = PROG_CAPABLE;
                end
                default: begin
                    prg_wr = 1'b0;
                end
            endcase
        end
    end

    // Register array: later writes in the same cycle take precedence
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            for (int i = 0; i < ddrs_pkg::NUM_REGS; i++) begin
                regs[i] <= ddrs_pkg::REG_RESET;
            end
        end else begin
            if (I_RO_WE && ro_idx[7] && ro_idx[6:0] < ddrs_pkg::RW_BASE) begin
                regs[ro_idx[6:0]] <= I_RO_DATA;
            end
            if (cnt_pulse) begin
                regs[cnt_idx[6:0]] <= regs[cnt_idx[6:0]] +
                                      32'h0000_0001;
            end
            if (prg_wr) begin
                regs[prg_wr_idx] <= prg_wr_data;
            end
            if (prg_state == PS_RESTORE) begin
                regs[restore_idx] <= nv_rdata;
            end
            if (imm_load) begin
                if (I_IMM_CMD.op == ddrs_pkg::SPEED_SET_CMD) begin
                    regs[speed_idx[6:0]] <= I_IMM_CMD.data;
                end else begin
                    regs[imm_idx[6:0]] <= I_IMM_CMD.data;
                end
            end
        end
    end

    // Program port sequencing; restore holds the port for a cycle
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            prg_state <= PS_IDLE;
            O_PRG_READY <= 1'b1;
            restore_idx <= 7'h00;
        end else begin
            unique case (prg_state)
                PS_IDLE: begin
                    if (nv_re) begin
                        prg_state <= PS_RESTORE;
                        O_PRG_READY <= 1'b0;
                        restore_idx <= a_idx[6:0];
                    end
                end
                PS_RESTORE: begin
                    prg_state <= PS_IDLE;
                    O_PRG_READY <= 1'b1;
                end
                default: begin
                    prg_state <= PS_IDLE;
                    O_PRG_READY <= 1'b1;
                end
            endcase
        end
    end

    // Upload count: single gives one, multi clamps to 1..10
    always_comb begin
        next_up_count = ddrs_pkg::UPLOAD_ONE;
        if (I_IMM_CMD.op == ddrs_pkg::MULTI_UPLOAD_CMD) begin
            if (I_IMM_CMD.count > ddrs_pkg::UPLOAD_MAX) begin
                next_up_count = ddrs_pkg::UPLOAD_MAX;
            end else if (I_IMM_CMD.count != 4'h0) begin
                next_up_count = I_IMM_CMD.count;
            end
        end
    end

    // Upload engine runs alongside the program port
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            up_state <= US_IDLE;
            up_ptr <= 8'h00;
            up_left <= 4'h0;
            O_UP_VALID <= 1'b0;
            O_UP_WORD <= '0;
        end else begin
            unique case (up_state)
                US_IDLE: begin
                    O_UP_VALID <= 1'b0;
                    if (imm_upload) begin
                        up_state <= US_SEND;
                        up_ptr <= I_IMM_CMD.reg_a;
                        up_left <= next_up_count;
                    end
                end
                US_SEND: begin
                    O_UP_VALID <= 1'b1;
                    O_UP_WORD.chr <= up_ptr;
                    O_UP_WORD.data <= up_idx[7] ? regs[up_idx[6:0]]
                                                : ddrs_pkg::REG_RESET;
                    O_UP_WORD.last <= (up_left == ddrs_pkg::UPLOAD_ONE);
                    up_ptr <= up_ptr + 8'h01;
                    up_left <= up_left - 4'h1;
                    if (up_left == ddrs_pkg::UPLOAD_ONE) begin
                        up_state <= US_IDLE;
                    end
                end
                default: begin
                    up_state <= US_IDLE;
                    O_UP_VALID <= 1'b0;
                end
            endcase
        end
    end

    // Registered view of the move speed
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SPEED <= ddrs_pkg::REG_RESET;
        end else begin
            O_SPEED <= regs[speed_idx[6:0]];
        end
    end

    ddrs_nv_slots u_nv (
        .i_clk(I_MCLK),
        .i_we(nv_we),
        .i_re(nv_re),
        .i_addr(nv_addr),
        .i_wdata(prg_wr_data),
        .o_rdata(nv_rdata)
    );

    ddrs_input_counter #(
        .ALT_RES(ALT_RES)
    ) u_cnt (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_din(I_DIN),
        .i_assign(cnt_assign),
        .i_sel(I_PRG_CMD.reg_b[ddrs_pkg::CA_IN_LSB +: 3]),
        .i_mode(ddrs_pkg::ddrs_cnt_mode_t'(
            I_PRG_CMD.reg_b[ddrs_pkg::CA_MODE_LSB +: 2])),
        .o_pulse(cnt_pulse)
    );

endmodule

`default_nettype wire

// File: testbench/ddrs_host_model.sv
/* Host controller model: command line and stored-program command ports.
   Assumes the store samples commands on the rising edge of i_clk. */
`timescale 1ns/1ps
`default_nettype none
module ddrs_host_model (
    input wire logic i_clk,
    input wire logic i_prg_ready,
    output logic o_imm_valid,
    output ddrs_pkg::ddrs_cmd_t o_imm_cmd,
    output logic o_prg_valid,
    output ddrs_pkg::ddrs_cmd_t o_prg_cmd
);
    initial begin
        o_imm_valid = 1'b0;
        o_imm_cmd = '0;
        o_prg_valid = 1'b0;
        o_prg_cmd = '0;
    end
    // Command line: one cycle per command, the only source of uploads
    task automatic imm(input ddrs_pkg::ddrs_op_t op, input logic [7:0] a,
                       input logic [3:0] n, input logic [31:0] d);
        @(posedge i_clk);
        #1 o_imm_valid = 1'b1;
        o_imm_cmd = '{op, a, a, 7'h00, n, d};
        @(posedge i_clk);
        #1 o_imm_valid = 1'b0;
        o_imm_cmd = ~o_imm_cmd;
    endtask
    // Program line: held until taken
    task automatic prg(input ddrs_pkg::ddrs_op_t op, input logic [7:0] a,
                       input logic [7:0] b, input logic [6:0] s,
                       input logic [31:0] d);
        @(posedge i_clk);
        #1 o_prg_valid = 1'b1;
        o_prg_cmd = '{op, a, b, s, 4'h0, d};
        @(posedge i_clk);
        for (int k = 0; k < 8; k++) begin
            if (i_prg_ready === 1'b1) break;
            @(posedge i_clk);
        end
        #1 o_prg_valid = 1'b0;
        o_prg_cmd = ~o_prg_cmd;
    endtask
endmodule
`default_nettype wire

// File: testbench/ddrs_store_checker.sv
/* Port checker for the data register store.
   Assumes it is bound into every ddrs_store instance. */
`timescale 1ns/1ps
`default_nettype none
module ddrs_store_checker (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_IMM_VALID,
    input wire ddrs_pkg::ddrs_cmd_t I_IMM_CMD,
    input wire logic I_PRG_VALID,
    input wire ddrs_pkg::ddrs_cmd_t I_PRG_CMD,
    input wire logic O_PRG_READY,
    input wire logic I_RO_WE,
    input wire logic [7:0] I_RO_CHAR,
    input wire logic [31:0] I_RO_DATA,
    input wire logic [7:0] I_DIN,
    input wire logic O_UP_VALID,
    input wire ddrs_pkg::ddrs_up_word_t O_UP_WORD,
    input wire logic [31:0] O_SPEED
);
    logic up_req;
    logic up_busy;
    logic req_d;
    logic rst_ok;
    logic [3:0] run_len;
    assign up_req = I_IMM_VALID && (I_IMM_CMD.op == ddrs_pkg::UPLOAD_ONE_CMD
        || I_IMM_CMD.op == ddrs_pkg::MULTI_UPLOAD_CMD);
    assign up_busy = req_d || (O_UP_VALID && !O_UP_WORD.last);
    assign rst_ok = I_PRG_VALID && O_PRG_READY
        && I_PRG_CMD.op == ddrs_pkg::NV_RESTORE_CMD
        && I_PRG_CMD.slot >= 7'h01 && I_PRG_CMD.slot <= 7'h64
        && I_PRG_CMD.reg_a >= 8'h30 && I_PRG_CMD.reg_a <= 8'h39;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            req_d <= 1'b0;
            run_len <= 4'h0;
        end else begin
            req_d <= up_req && !up_busy;
            run_len <= (O_UP_VALID && !O_UP_WORD.last) ? run_len + 4'h1 : 4'h0;
        end
    end
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    AST_UP_SINGLE: assert property (
        up_req && !up_busy && I_IMM_CMD.op == ddrs_pkg::UPLOAD_ONE_CMD |->
        ##2 O_UP_VALID && O_UP_WORD.last
        && O_UP_WORD.chr == $past(I_IMM_CMD.reg_a, 2))
        else $error("single upload word wrong");
    AST_UP_MULTI: assert property (
        up_req && !up_busy && I_IMM_CMD.op == ddrs_pkg::MULTI_UPLOAD_CMD |->
        ##2 O_UP_VALID && O_UP_WORD.chr == $past(I_IMM_CMD.reg_a, 2))
        else $error("multi upload first word wrong");
    AST_UP_STEP: assert property (
        O_UP_VALID && !O_UP_WORD.last |=>
        O_UP_VALID && O_UP_WORD.chr == $past(O_UP_WORD.chr) + 8'h01)
        else $error("upload sequence broken");
    AST_UP_MAX: assert property (
        O_UP_VALID |-> run_len < 4'h9 || (run_len == 4'h9 && O_UP_WORD.last))
        else $error("upload longer than ten words");
    AST_UP_CAUSE: assert property (
        $rose(O_UP_VALID) |-> $past(up_req && !up_busy, 2))
        else $error("upload word without request");
    AST_SPEED: assert property (
        I_IMM_VALID && (I_IMM_CMD.op == ddrs_pkg::SPEED_SET_CMD
        || (I_IMM_CMD.op == ddrs_pkg::LOAD_NOW_CMD && I_IMM_CMD.reg_a == 8'h56))
        |-> ##2 O_SPEED == $past(I_IMM_CMD.data, 2))
        else $error("speed not taken from load");
    AST_RESTORE_GAP: assert property (
        rst_ok |=> !O_PRG_READY ##1 O_PRG_READY)
        else $error("restore ready gap wrong");
    AST_READY_ONE: assert property (
        !O_PRG_READY |=> O_PRG_READY)
        else $error("program port stalled too long");
    AST_READY_CAUSE: assert property (
        $fell(O_PRG_READY) |->
        $past(I_PRG_VALID && I_PRG_CMD.op == ddrs_pkg::NV_RESTORE_CMD))
        else $error("program port stalled without restore");
    COV_MULTI: cover property (O_UP_VALID && run_len == 4'h9);
    COV_RESTORE: cover property (rst_ok ##1 !O_PRG_READY);
    COV_SINGLE: cover property ($rose(O_UP_VALID) && O_UP_WORD.last);
endmodule
bind ddrs_store ddrs_store_checker u_chk (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
    .I_IMM_VALID(I_IMM_VALID), .I_IMM_CMD(I_IMM_CMD),
    .I_PRG_VALID(I_PRG_VALID), .I_PRG_CMD(I_PRG_CMD),
    .O_PRG_READY(O_PRG_READY), .I_RO_WE(I_RO_WE), .I_RO_CHAR(I_RO_CHAR),
    .I_RO_DATA(I_RO_DATA), .I_DIN(I_DIN), .O_UP_VALID(O_UP_VALID),
    .O_UP_WORD(O_UP_WORD), .O_SPEED(O_SPEED));
`default_nettype wire

// File: testbench/test_drive_data_register_store.sv
/* Self-checking bench for the data register store.
   Assumes the host model drives both command ports. */
`timescale 1ns/1ps
`default_nettype none
module test_drive_data_register_store;
    logic clk, rst_n, imm_v, prg_v, prg_rdy, ro_we, up_v;
    ddrs_pkg::ddrs_cmd_t imm_c, prg_c;
    ddrs_pkg::ddrs_up_word_t up_w;
    logic [7:0] ro_ch, din;
    logic [31:0] ro_d, speed;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [31:0] upq[$];
    ddrs_store u_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_IMM_VALID(imm_v),
        .I_IMM_CMD(imm_c), .I_PRG_VALID(prg_v), .I_PRG_CMD(prg_c),
        .O_PRG_READY(prg_rdy), .I_RO_WE(ro_we), .I_RO_CHAR(ro_ch),
        .I_RO_DATA(ro_d), .I_DIN(din), .O_UP_VALID(up_v), .O_UP_WORD(up_w),
        .O_SPEED(speed));
    ddrs_host_model u_host (.i_clk(clk), .i_prg_ready(prg_rdy),
        .o_imm_valid(imm_v), .o_imm_cmd(imm_c), .o_prg_valid(prg_v),
        .o_prg_cmd(prg_c));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic upload(input ddrs_pkg::ddrs_op_t op, input logic [7:0] a,
                          input logic [3:0] n);
        upq.delete();
        u_host.imm(op, a, n, 32'h0);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            if (up_v === 1'b1) begin
                upq.push_back(up_w.data);
                if (up_w.last === 1'b1) break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        upload(ddrs_pkg::UPLOAD_ONE_CMD, a, 4'h1);
        v = (upq.size() == 1) ? upq[0] : 32'hxxxx_xxxx;
    endtask
    task automatic t_load();
        logic [31:0] v;
        @(posedge clk);
        #1 ro_we = 1'b1;
        @(posedge clk);
        #1 ro_we = 1'b0;
        u_host.imm(ddrs_pkg::LOAD_NOW_CMD, 8'h41, 4'h0, 32'h1234);
        u_host.imm(ddrs_pkg::LOAD_NOW_CMD, 8'h42, 4'h0, 32'h5678);
        u_host.imm(ddrs_pkg::LOAD_NOW_CMD, 8'h61, 4'h0, 32'h99);
        rd(8'h61, v);
        chk("read-only a", 32'h4d, v);
        upload(ddrs_pkg::MULTI_UPLOAD_CMD, 8'h41, 4'h2);
        chk("words of 2", 32'h2, 32'(upq.size()));
        chk("A", 32'h1234, upq[0]);
        chk("B", 32'h5678, upq[1]);
        upload(ddrs_pkg::MULTI_UPLOAD_CMD, 8'h41, 4'hf);
        chk("words of 15", 32'ha, 32'(upq.size()));
        upload(ddrs_pkg::MULTI_UPLOAD_CMD, 8'h41, 4'h0);
        chk("words of 0", 32'h1, 32'(upq.size()));
        u_host.imm(ddrs_pkg::SPEED_SET_CMD, 8'h56, 4'h0, 32'h10);
        @(posedge clk);
        #1 chk("speed cmd", 32'h10, speed);
        u_host.imm(ddrs_pkg::LOAD_NOW_CMD, 8'h56, 4'h0, 32'h960);
        @(posedge clk);
        #1 chk("speed load", 32'h960, speed);
        $display("test load_upload done");
    endtask
    task automatic t_prog();
        logic [31:0] v;
        u_host.prg(ddrs_pkg::LOAD_QUEUED_CMD, 8'h30, 8'h30, 7'h0, 32'h5);
        u_host.prg(ddrs_pkg::INC_CMD, 8'h30, 8'h30, 7'h0, 32'h0);
        u_host.prg(ddrs_pkg::LOAD_QUEUED_CMD, 8'h31, 8'h31, 7'h0, '1);
        u_host.prg(ddrs_pkg::INC_CMD, 8'h31, 8'h31, 7'h0, 32'h0);
        u_host.prg(ddrs_pkg::DEC_CMD, 8'h32, 8'h32, 7'h0, 32'h0);
        u_host.prg(ddrs_pkg::INC_CMD, 8'h61, 8'h61, 7'h0, 32'h0);
        u_host.prg(ddrs_pkg::COPY_CMD, 8'h41, 8'h33, 7'h0, 32'h0);
        u_host.prg(ddrs_pkg::COPY_CMD, 8'h41, 8'h62, 7'h0, 32'h0);
        u_host.prg(ddrs_pkg::NV_SAVE_CMD, 8'h30, 8'h30, 7'h05, 32'h0);
        u_host.prg(ddrs_pkg::NV_SAVE_CMD, 8'h32, 8'h32, 7'h64, 32'h0);
        u_host.prg(ddrs_pkg::LOAD_QUEUED_CMD, 8'h30, 8'h30, 7'h0, 32'h0);
        u_host.prg(ddrs_pkg::NV_RESTORE_CMD, 8'h30, 8'h30, 7'h05, 32'h0);
        u_host.prg(ddrs_pkg::NV_RESTORE_CMD, 8'h31, 8'h31, 7'h64, 32'h0);
        u_host.prg(ddrs_pkg::NV_RESTORE_CMD, 8'h30, 8'h30, 7'h65, 32'h0);
        upload(ddrs_pkg::MULTI_UPLOAD_CMD, 8'h30, 4'h4);
        chk("inc and restore", 32'h6, upq[0]);
        chk("slot 100", 32'hffff_ffff, upq[1]);
        chk("dec wrap", 32'hffff_ffff, upq[2]);
        chk("copy dst", 32'h1234, upq[3]);
        rd(8'h41, v);
        chk("copy src", 32'h1234, v);
        rd(8'h61, v);
        chk("inc read-only", 32'h4d, v);
        rd(8'h62, v);
        chk("copy to read-only", 32'h0, v);
        $display("test program done");
    endtask
    task automatic t_count();
        logic [31:0] v;
        for (int m = 0; m < 4; m++) begin
            #1 din[2] = (m == 1);
            u_host.prg(ddrs_pkg::INPUT_COUNT_ASSIGN_CMD, 8'h49,
                {2'b00, m[1:0], 4'h2}, 7'h0, 32'h0);
            u_host.prg(ddrs_pkg::LOAD_QUEUED_CMD, 8'h49, 8'h49, 7'h0, 32'h0);
            if (m < 2) begin
                din[2] = (m == 0);
                repeat (ddrs_pkg::TIMER_CYCLES * 5 / 2) @(posedge clk);
                #1 din[2] = (m == 1);
            end else begin
                repeat (3) begin
                    repeat (5) @(posedge clk);
                    #1 din[2] = 1'b1;
                    repeat (5) @(posedge clk);
                    #1 din[2] = 1'b0;
                end
            end
            repeat (10) @(posedge clk);
            rd(8'h49, v);
            if (m < 2) begin
                chk1("level count", 1'b1, v >= 2 && v <= 3);
            end else begin
                chk("edge count", 32'h3, v);
            end
        end
        $display("test counter done");
    endtask
    initial begin
        rst_n = 1'b0;
        ro_we = 1'b0;
        ro_ch = 8'h61;
        ro_d = 32'h4d;
        din = 8'h00;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        t_load();
        t_prog();
        t_count();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
